//--- rtl/rfid_consts.svh
// constants of the passive tag protocol core
`ifndef RFID_CONSTS_SVH
`define RFID_CONSTS_SVH
`define CLK_HZ          100000000
`define BLOCKS          32
`define BLK_CFG         5'h00
`define BLK_ID          5'h01
`define BLK_QUICK0      5'h03
`define BLK_QUICK1      5'h04
`define BLK_QUICK2      5'h05
`define QUICK_BIT       31
`define TALK_BIT        30
`define CFG_RESET       32'h8000_0000
`define CFG_FREE_MASK   32'hC000_0000
`define UP_RATE_BPS     70000
`define HALF_BIT_CYCLES (`CLK_HZ / (2 * `UP_RATE_BPS))
`define RESP_MAX_BITS   160
`define SLOT_CYCLES     (`RESP_MAX_BITS * 2 * `HALF_BIT_CYCLES)
`define LISTEN_TIME_US  1000
`define LISTEN_CYCLES   (`LISTEN_TIME_US * (`CLK_HZ / 1000000))
`define PROG_TIME_US    50
`define PROG_CYCLES     (`PROG_TIME_US * (`CLK_HZ / 1000000))
`define CAL_MIN_CYCLES  20'h00040
`define CMD_NIBBLES     11
`define OP_REQ          4'h1
`define OP_SKIP         4'h2
`define OP_SLEEP        4'h3
`define OP_SELECT       4'h4
`define OP_READ         4'h5
`define OP_WRITE        4'h6
`define OP_LOCK         4'h7
`define OP_END          4'h8
`endif

//--- rtl/rfid_pkg.sv
// types of the passive tag protocol core
package rfid_pkg;
    typedef enum logic [3:0] {
        ST_BOOT   = 4'b0000,
        ST_IDLE   = 4'b0001,
        ST_SLOT   = 4'b0010,
        ST_SEND   = 4'b0011,
        ST_LISTEN = 4'b0100,
        ST_SEL    = 4'b0101,
        ST_PROG   = 4'b0110,
        ST_SLEEP  = 4'b0111
    } core_state_e;
    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_CAL  = 2'b01,
        D_DATA = 2'b10
    } dec_state_e;
endpackage

//--- rtl/ppm_if.sv
// downlink symbol carrier from decoder to core
`timescale 1ns/1ns
`default_nettype none
interface ppm_if;
    logic       frame_start;
    logic       frame_end;
    logic       nib_valid;
    logic [3:0] nib;
    modport dec  (output frame_start, output frame_end, output nib_valid, output nib);
    modport core (input frame_start, input frame_end, input nib_valid, input nib);
endinterface
`default_nettype wire

//--- rtl/ppm_decoder.sv
// 1-of-16 pulse position decoder with calibration pulse
`timescale 1ns/1ns
`default_nettype none
`include "rfid_consts.svh"
module ppm_decoder
    import rfid_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic gap_s,
    ppm_if.dec        dn
);
    dec_state_e  st_q;
    logic        gap_prev_q;
    logic [19:0] cnt_q;
    logic [15:0] slot_len_q;
    logic [15:0] slot_cnt_q;
    logic [3:0]  pos_q;
    logic        got_q;

    // edge, slot tick and symbol end
    wire gap_rise = gap_s & ~gap_prev_q;
    wire slot_tick = (slot_cnt_q == slot_len_q - 16'h0001);
    wire sym_end = slot_tick & (pos_q == 4'hF);
    wire cal_ok = (cnt_q >= `CAL_MIN_CYCLES);
    wire cnt_full = (cnt_q == 20'hFFFFF);

    // calibration interval measures sixteen slots
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q           <= D_IDLE;
            gap_prev_q     <= 1'b0;
            cnt_q          <= 20'h00000;
            slot_len_q     <= 16'h0001;
            slot_cnt_q     <= 16'h0000;
            pos_q          <= 4'h0;
            got_q          <= 1'b0;
            dn.frame_start <= 1'b0;
            dn.frame_end   <= 1'b0;
            dn.nib_valid   <= 1'b0;
            dn.nib         <= 4'h0;
        end
        else
        begin
            gap_prev_q     <= gap_s;
            dn.frame_start <= 1'b0;
            dn.frame_end   <= 1'b0;
            dn.nib_valid   <= 1'b0;
            cnt_q          <= cnt_full ? cnt_q : cnt_q + 20'h00001;
            case (st_q)
                D_IDLE:
                begin
                    if (gap_rise)
                    begin
                        st_q  <= D_CAL;
                        cnt_q <= 20'h00001; // closing gap then reads the full interval
                    end
                end
                D_CAL:
                begin
                    if (gap_rise & cal_ok)
                    begin
                        st_q           <= D_DATA; // RULE12
                        slot_len_q     <= cnt_q[19:4];
                        slot_cnt_q     <= 16'h0000;
                        pos_q          <= 4'h0;
                        got_q          <= 1'b0;
                        dn.frame_start <= 1'b1;
                    end
                    else if (gap_rise)
                        cnt_q <= 20'h00001;
                    else if (cnt_full)
                        st_q <= D_IDLE;
                end
                D_DATA:
                begin
                    slot_cnt_q <= slot_tick ? 16'h0000 : slot_cnt_q + 16'h0001;
                    pos_q      <= slot_tick ? pos_q + 4'h1 : pos_q;
                    if (gap_rise & ~got_q)
                    begin
                        dn.nib_valid <= 1'b1; // RULE9
                        dn.nib       <= pos_q;
                        got_q        <= 1'b1;
                    end
                    if (sym_end)
                    begin
                        got_q <= 1'b0;
                        if (~got_q & ~gap_rise)
                        begin
                            st_q         <= D_IDLE;
                            dn.frame_end <= 1'b1;
                        end
                    end
                end
                default: st_q <= D_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- rtl/rfid_tag_protocol_core.sv
// protocol core of the passive contactless tag
`timescale 1ns/1ns
`default_nettype none
`include "rfid_consts.svh"
// Overview of operation
// RULE1 - memory of 32 blocks, 32 bits each
// RULE2 - blocks 0-2 device, 3-31 user data
// RULE3 - block 1 holds fixed tag identifier
// RULE4 - other blocks written whole by reader
// RULE5 - lockable blocks, block 0 bits 30-31 free
// RULE6 - block 0 bits 30-31 select start mode
// RULE7 - tag-first: send quick response at power-up; core never does, as reset loads CFG_RESET (bit 30 clear) into block 0
// RULE8 - reader-first: silent until valid command
// RULE9 - downlink is 1-of-16 pulse position
// RULE10 - uplink Manchester at 70 kbit/s
// RULE11 - reader sends calibration pulse first
// RULE12 - calibration pulse sets decoder slot timing
// RULE13 - modulation transistor on cloaks antenna
// RULE14 - modulate only inside own time slot
// RULE15 - torn writes detectable, block stays intact
// RULE16 - protected or identifier block never changes
// RULE17 - bit 31 picks request or skip command
// RULE18 - bit 30 picks tag-first or reader-first; core reads it only in ST_BOOT, after reset cleared it, so always reader-first
// RULE19 - 1 ms listening window after quick response
// RULE20 - sleep code ignores all until power loss
module rfid_tag_protocol_core
    import rfid_pkg::*;
#(
    parameter logic [31:0] TAG_ID        = 32'h1234_5678, // arbitrary value
    parameter logic [23:0] LISTEN_CYCLES = 24'(`LISTEN_CYCLES),
    parameter logic [23:0] PROG_CYCLES   = 24'(`PROG_CYCLES),
    parameter logic [23:0] SLOT_CYCLES   = 24'(`SLOT_CYCLES),
    parameter logic [9:0]  HALF_BIT      = 10'(`HALF_BIT_CYCLES)
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic rf_gap,
    input  wire logic rf_present,
    output var  logic mod_on,
    output var  logic write_torn,
    output var  logic asleep
);
    // pin synchronisers
    logic gap_m_q, gap_s_q, pres_m_q, pres_s_q;
    always_ff @(posedge sys_clk)
    begin
        gap_m_q  <= rf_gap;
        gap_s_q  <= gap_m_q;
        pres_m_q <= rf_present;
        pres_s_q <= pres_m_q;
    end

    ppm_if dn ();
    ppm_decoder u_dec (
        .sys_clk (sys_clk),
        .rst     (rst),
        .gap_s   (gap_s_q),
        .dn      (dn)
    );

    logic [31:0]  mem_q [0:`BLOCKS-1];
    logic [31:0]  prot_q;
    logic [3:0]   nb_q [0:`CMD_NIBBLES-1];
    logic [3:0]   ncnt_q;
    logic         busy_q;
    core_state_e  st_q, st_d, after_q, after_d;
    logic [23:0]  tmr_q, tmr_d;
    logic [3:0]   slot_q, slot_d;
    logic [159:0] resp_q, resp_d;
    logic [7:0]   len_q, len_d, bit_q, bit_d;
    logic [9:0]   half_q, half_d;
    logic         ph_q, ph_d, timed_q, timed_d, torn_d;
    logic         commit, lock_set;

    // expected nibble count per opcode
    function automatic logic [3:0] cmd_len(input logic [3:0] op);
        case (op)
            `OP_REQ:   cmd_len = 4'h2;
            `OP_READ:  cmd_len = 4'h3;
            `OP_LOCK:  cmd_len = 4'h3;
            `OP_WRITE: cmd_len = 4'hB;
            `OP_SKIP, `OP_SLEEP, `OP_SELECT, `OP_END: cmd_len = 4'h1;
            default:   cmd_len = 4'hF;
        endcase
    endfunction

    // bits a write may change in a block
    function automatic logic [31:0] wmask(input logic [4:0] blk, input logic prot);
        if (blk == `BLK_ID)
            wmask = 32'h0000_0000; // RULE3
        else if (prot & (blk == `BLK_CFG))
            wmask = `CFG_FREE_MASK; // RULE5
        else if (prot)
            wmask = 32'h0000_0000; // RULE16
        else
            wmask = 32'hFFFF_FFFF; // RULE4
    endfunction

    // command fields and configuration decode
    wire [3:0]   op      = nb_q[0];
    wire [4:0]   addr    = {nb_q[1][0], nb_q[2]};
    wire [31:0]  wdata   = {nb_q[3], nb_q[4], nb_q[5], nb_q[6],
                            nb_q[7], nb_q[8], nb_q[9], nb_q[10]};
    wire         cmd_ok  = dn.frame_end & (ncnt_q == cmd_len(op));
    wire         quick   = mem_q[`BLK_CFG][`QUICK_BIT]; // RULE17
    wire         talk    = mem_q[`BLK_CFG][`TALK_BIT]; // RULE18
    wire [159:0] q_resp  = {mem_q[`BLK_ID], mem_q[`BLK_QUICK0], mem_q[`BLK_QUICK1],
                            mem_q[`BLK_QUICK2], 32'h0000_0000};
    wire [159:0] id_resp = {mem_q[`BLK_ID], 128'h0};
    wire [159:0] b_resp  = {mem_q[addr], 128'h0};
    wire [31:0]  merged  = (mem_q[addr] & ~wmask(addr, prot_q[addr]))
                         | (wdata & wmask(addr, prot_q[addr]));
    wire         half_end = (half_q == HALF_BIT - 10'h001);
    wire         last_bit = (bit_q == len_q - 8'h01);

    // protocol sequencing
    always_comb
    begin
        st_d     = st_q;
        after_d  = after_q;
        tmr_d    = tmr_q;
        slot_d   = slot_q;
        resp_d   = resp_q;
        len_d    = len_q;
        bit_d    = bit_q;
        half_d   = half_q;
        ph_d     = ph_q;
        timed_d  = timed_q;
        torn_d   = write_torn;
        commit   = 1'b0;
        lock_set = 1'b0;
        case (st_q)
            ST_BOOT:
            begin
                if (quick & talk) // RULE6
                begin
                    st_d    = ST_SLOT; // RULE7
                    slot_d  = 4'h0;
                    resp_d  = q_resp;
                    len_d   = 8'h80;
                    after_d = ST_LISTEN;
                    timed_d = 1'b1;
                end
                else
                    st_d = ST_IDLE; // RULE8
            end
            ST_IDLE:
            begin
                if (cmd_ok & quick & (op == `OP_REQ))
                begin
                    st_d    = ST_SLOT;
                    slot_d  = TAG_ID[3:0] & nb_q[1]; // RULE14
                    resp_d  = q_resp;
                    len_d   = 8'h80;
                    after_d = ST_LISTEN;
                    timed_d = 1'b1;
                end
                else if (cmd_ok & ~quick & (op == `OP_SKIP))
                begin
                    st_d    = ST_SLOT;
                    slot_d  = 4'h0;
                    resp_d  = id_resp;
                    len_d   = 8'h20;
                    after_d = ST_LISTEN;
                    timed_d = 1'b0;
                end
            end
            ST_SLOT:
            begin
                tmr_d = tmr_q + 24'h000001;
                if (slot_q == 4'h0)
                begin
                    st_d   = ST_SEND;
                    tmr_d  = 24'h000000;
                    bit_d  = 8'h00;
                    half_d = 10'h000;
                    ph_d   = 1'b0;
                end
                else if (tmr_q == SLOT_CYCLES - 24'h000001)
                begin
                    slot_d = slot_q - 4'h1; // RULE14
                    tmr_d  = 24'h000000;
                end
            end
            ST_SEND:
            begin
                half_d = half_end ? 10'h000 : half_q + 10'h001; // RULE10
                if (half_end)
                begin
                    ph_d = ~ph_q;
                    if (ph_q)
                    begin
                        resp_d = {resp_q[158:0], 1'b0};
                        bit_d  = bit_q + 8'h01;
                        if (last_bit)
                        begin
                            st_d  = after_q;
                            tmr_d = 24'h000000;
                        end
                    end
                end
            end
            ST_LISTEN:
            begin
                tmr_d = busy_q ? tmr_q : tmr_q + 24'h000001;
                if (cmd_ok & (op == `OP_SLEEP))
                    st_d = ST_SLEEP; // RULE20
                else if (cmd_ok & (op == `OP_SELECT))
                    st_d = ST_SEL;
                else if (timed_q & ~busy_q & (tmr_q == LISTEN_CYCLES - 24'h000001))
                    st_d = ST_IDLE; // RULE19
            end
            ST_SEL:
            begin
                slot_d  = 4'h0;
                len_d   = 8'h20;
                after_d = ST_SEL;
                if (cmd_ok & (op == `OP_READ))
                begin
                    st_d   = ST_SLOT;
                    resp_d = b_resp;
                end
                else if (cmd_ok & (op == `OP_WRITE))
                begin
                    st_d  = ST_PROG;
                    tmr_d = 24'h000000;
                end
                else if (cmd_ok & (op == `OP_LOCK))
                begin
                    st_d     = ST_SLOT;
                    lock_set = 1'b1; // RULE5
                    resp_d   = b_resp;
                end
                else if (cmd_ok & (op == `OP_END))
                begin
                    st_d    = ST_SLOT;
                    resp_d  = id_resp;
                    after_d = ST_SLEEP;
                end
            end
            ST_PROG:
            begin
                tmr_d = tmr_q + 24'h000001;
                if (~pres_s_q)
                begin
                    st_d   = ST_IDLE; // RULE15
                    torn_d = 1'b1;
                end
                else if (tmr_q == PROG_CYCLES - 24'h000001)
                begin
                    commit = 1'b1; // RULE15
                    torn_d = 1'b0;
                    st_d   = ST_SEL;
                end
            end
            ST_SLEEP: st_d = ST_SLEEP; // RULE20
            default:  st_d = ST_IDLE;
        endcase
    end

    // Manchester level: first half is the bit, second half its inverse
    wire mod_d = (st_d == ST_SEND) & (ph_d ? ~resp_d[159] : resp_d[159]);

    // sequencer registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q       <= ST_BOOT;
            after_q    <= ST_IDLE;
            tmr_q      <= 24'h000000;
            slot_q     <= 4'h0;
            resp_q     <= 160'h0;
            len_q      <= 8'h00;
            bit_q      <= 8'h00;
            half_q     <= 10'h000;
            ph_q       <= 1'b0;
            timed_q    <= 1'b0;
            write_torn <= 1'b0;
            mod_on     <= 1'b0;
            asleep     <= 1'b0;
        end
        else
        begin
            st_q       <= st_d;
            after_q    <= after_d;
            tmr_q      <= tmr_d;
            slot_q     <= slot_d;
            resp_q     <= resp_d;
            len_q      <= len_d;
            bit_q      <= bit_d;
            half_q     <= half_d;
            ph_q       <= ph_d;
            timed_q    <= timed_d;
            write_torn <= torn_d;
            mod_on     <= mod_d; // RULE13
            asleep     <= (st_d == ST_SLEEP);
        end
    end

    // downlink nibble collection
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ncnt_q <= 4'h0;
            busy_q <= 1'b0;
        end
        else if (dn.frame_start)
        begin
            ncnt_q <= 4'h0;
            busy_q <= 1'b1;
        end
        else
        begin
            busy_q <= busy_q & ~dn.frame_end;
            if (dn.nib_valid & (ncnt_q < 4'hC))
                ncnt_q <= ncnt_q + 4'h1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (dn.nib_valid & (ncnt_q < 4'(`CMD_NIBBLES)))
            nb_q[ncnt_q] <= dn.nib;
    end

    // block memory, written atomically only at commit
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < `BLOCKS; i++)
                mem_q[i] <= 32'h0000_0000; // RULE1
            mem_q[`BLK_CFG] <= `CFG_RESET; // RULE2
            mem_q[`BLK_ID]  <= TAG_ID; // RULE3
            prot_q          <= 32'h0000_0002;
        end
        else
        begin
            if (commit)
                mem_q[addr] <= merged; // RULE16
            if (lock_set)
                prot_q[addr] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- testbench/rfid_chk.sv
// concurrent checks on the tag core ports
`timescale 1ns/1ns
`default_nettype none
`include "rfid_consts.svh"
module rfid_chk #(
    parameter int HALF = `HALF_BIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic rf_gap,
    input wire logic rf_present,
    input wire logic mod_on,
    input wire logic write_torn,
    input wire logic asleep
);
    logic [11:0] hi_q;
    logic [11:0] lo_q;
    logic [3:0]  low_ago_q;
    logic        gap_seen_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // run lengths of modulation levels, time since field loss
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            hi_q       <= 12'h000;
            lo_q       <= 12'hFFF;
            low_ago_q  <= 4'hF;
            gap_seen_q <= 1'b0;
        end
        else
        begin
            hi_q       <= mod_on ? hi_q + 12'h001 : 12'h000;
            lo_q       <= mod_on ? 12'h000 : lo_q + {11'h000, lo_q != 12'hFFF};
            low_ago_q  <= rf_present ? low_ago_q + {3'h0, low_ago_q != 4'hF} : 4'h0;
            gap_seen_q <= gap_seen_q | rf_gap;
        end
    end
    sequence s_quiet8;
        !mod_on [*8];
    endsequence
    AST_RST_CLR: assert property (disable iff (1'b0)
        rst |=> !mod_on && !write_torn && !asleep) else $error("outputs not cleared by reset");
    AST_BOOT_QUIET: assert property ($rose(mod_on) |-> gap_seen_q)
        else $error("modulation before any reader command");
    AST_SLEEP_QUIET: assert property (asleep |-> !mod_on)
        else $error("modulation while asleep");
    AST_SLEEP_HOLD: assert property (asleep |=> asleep)
        else $error("left sleep without reset");
    AST_SLEEP_IN: assert property ($rose(asleep) |-> s_quiet8 ##1 asleep)
        else $error("sleep entry not quiet");
    AST_HI_RUN: assert property ($fell(mod_on) |-> hi_q == HALF || hi_q == 2 * HALF)
        else $error("cloaked run not one or two half bits");
    AST_LO_RUN: assert property ($rose(mod_on) && lo_q <= 12'(2 * HALF) |->
        lo_q == HALF || lo_q == 2 * HALF) else $error("uncloaked run off half bit");
    AST_GAP_QUIET: assert property (rf_gap |-> !mod_on)
        else $error("modulation during downlink");
    AST_TORN_CAUSE: assert property ($rose(write_torn) |-> low_ago_q < 4'h8)
        else $error("torn flag without field loss");
endmodule
`default_nettype wire

//--- testbench/reader_model.sv
// reader model: pulse position downlink, manchester uplink receiver
`timescale 1ns/1ns
`default_nettype none
`include "rfid_consts.svh"
module reader_model #(
    parameter int HALF = `HALF_BIT_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic mod_on,
    output var  logic gap
);
    int           cyc = 0;
    int           tend = 0;
    int           n_rep = 0;
    int           bad = 0;
    int           len = 0;
    logic [127:0] data;
    event         done;
    initial gap = 1'b0;
    // free cycle count, used to place the first reply edge
    always @(posedge sys_clk) cyc <= cyc + 1;
    // one carrier gap, three cycles long
    task automatic pulse();
        gap <= 1'b1;
        repeat (3) @(negedge sys_clk);
        gap <= 1'b0;
    endtask
    // calibration pair 160 cycles apart, then one gap per symbol
    task automatic frame(input logic [43:0] nb, input int cnt);
        int pos;
        int n;
        @(negedge sys_clk);
        pulse();
        repeat (157) @(negedge sys_clk);
        pulse();
        pos = 3;
        for (int k = 0; k < cnt; k++)
        begin
            n = int'(nb[4 * (cnt - 1 - k) +: 4]);
            repeat (n * 10 + 4 - pos) @(negedge sys_clk);
            pulse();
            repeat (153 - n * 10) @(negedge sys_clk);
            pos = 0;
        end
        repeat (160) @(negedge sys_clk); // silent symbol ends frame
        tend = cyc;
    endtask
    // late first edge means a leading zero bit
    initial forever
    begin
        logic a;
        logic b;
        @(posedge sys_clk iff mod_on);
        data = 128'h0;
        len = 0;
        if (cyc - tend > HALF / 2 + 5)
        begin
            len = 1;
            repeat (HALF) @(posedge sys_clk);
        end
        do
        begin
            repeat (HALF / 2) @(posedge sys_clk);
            a = mod_on;
            repeat (HALF) @(posedge sys_clk);
            b = mod_on;
            repeat (HALF / 2) @(posedge sys_clk);
            if (a | b)
            begin
                if (a == b)
                    bad++;
                data = {data[126:0], a};
                len++;
            end
        end while (a | b);
        n_rep++;
        ->done;
    end
endmodule
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench of the tag protocol core
`timescale 1ns/1ns
`default_nettype none
`include "rfid_consts.svh"
module tb;
    import rfid_pkg::*;
    typedef struct {int len; logic [127:0] d;} rep_s;
    localparam logic [31:0] TAG = 32'hA5C3_0F96; // arbitrary value
    logic        sys_clk;
    logic        rst;
    logic        rf_gap;
    logic        rf_present;
    logic        mod_on;
    logic        write_torn;
    logic        asleep;
    logic [31:0] rnd;
    rep_s        exp_q[$];
    rep_s        e;
    int          failures = 0;
    int          num_checks = 0;
    rfid_tag_protocol_core #(
        .TAG_ID        (TAG),
        .LISTEN_CYCLES (24'h0007D0),
        .PROG_CYCLES   (24'h000032),
        .SLOT_CYCLES   (24'h001388),
        .HALF_BIT      (10'h00A)
    ) dut (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .rf_gap     (rf_gap),
        .rf_present (rf_present),
        .mod_on     (mod_on),
        .write_torn (write_torn),
        .asleep     (asleep)
    );
    reader_model #(.HALF (32'h0000_000A)) rdr (
        .sys_clk (sys_clk),
        .mod_on  (mod_on),
        .gap     (rf_gap)
    );
    // 100 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [127:0] x, input logic [127:0] s);
        num_checks++;
        if (x !== s)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // note an expected reply and wait until the monitor took it
    task automatic reply(input int len, input logic [127:0] d);
        rep_s r;
        r.len = len;
        r.d = d;
        exp_q.push_back(r);
        wait (exp_q.size() == 0);
        repeat (20) @(negedge sys_clk);
    endtask
    task automatic quiet(input int n);
        repeat (n) @(negedge sys_clk);
        chk("mod_on idle", 128'h0, 128'(mod_on));
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        rdr.frame({4'h6, 3'h0, a[4], a[3:0], d}, 11);
        repeat (100) @(negedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] op, input logic [4:0] a, input logic [31:0] d);
        rdr.frame({32'h0, op, 3'h0, a[4], a[3:0]}, 3);
        reply(32, {96'h0, d});
    endtask
    // reply monitor: oldest note against decoded reply
    always @(rdr.done)
    begin
        if (exp_q.size() == 0)
            chk("unexpected reply", 128'h0, 128'h1);
        else
        begin
            e = exp_q.pop_front();
            chk("reply length", 128'(e.len), 128'(rdr.len));
            chk("reply data", e.d, rdr.data);
        end
    end
    initial
    begin
        // about half again the length of the full scenario list
        repeat (60000) @(posedge sys_clk);
        failures++;
        test_done();
    end
    initial
    begin
        rst = 1'b1;
        rf_present = 1'b1;
        rnd = $urandom(32'hC402_72B8);
        rnd = $urandom;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        quiet(3000);
        rdr.frame(44'h2, 1);
        quiet(3000);
        rdr.frame(44'h10, 2);
        reply(128, {TAG, 96'h0});
        rdr.frame(44'h4, 1);
        repeat (50) @(negedge sys_clk);
        wr(5'h03, rnd);
        rd(4'h7, 5'h03, rnd);
        wr(5'h03, ~rnd);
        rd(4'h5, 5'h03, rnd);
        wr(5'h01, ~TAG);
        rd(4'h5, 5'h01, TAG);
        rdr.frame({4'h6, 8'h04, ~rnd}, 11);
        repeat (5) @(negedge sys_clk);
        rf_present = 1'b0;
        repeat (20) @(negedge sys_clk);
        rf_present = 1'b1;
        repeat (100) @(negedge sys_clk);
        chk("write_torn set", 128'h1, 128'(write_torn));
        rdr.frame(44'h10, 2);
        reply(128, {TAG, rnd, 64'h0});
        repeat (2100) @(negedge sys_clk); // listening window runs out
        rdr.frame(44'h10, 2);
        reply(128, {TAG, rnd, 64'h0});
        rdr.frame(44'h4, 1);
        repeat (50) @(negedge sys_clk);
        wr(5'h04, rnd);
        chk("write_torn clear", 128'h0, 128'(write_torn));
        rd(4'h5, 5'h04, rnd);
        rdr.frame(44'h8, 1);
        reply(32, {96'h0, TAG});
        chk("asleep", 128'h1, 128'(asleep));
        rdr.frame(44'h10, 2);
        quiet(3000);
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        chk("asleep after reset", 128'h0, 128'(asleep));
        chk("manchester halves", 128'h0, 128'(rdr.bad));
        test_done();
    end
endmodule
bind rfid_tag_protocol_core rfid_chk #(.HALF (32'h0000_000A)) chk_i (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .rf_gap     (rf_gap),
    .rf_present (rf_present),
    .mod_on     (mod_on),
    .write_torn (write_torn),
    .asleep     (asleep)
);
`default_nettype wire
